// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import tmx_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic c2f, c1e, c0r, c1r, ext, aden;
  logic adc_trig, irq0, irq1, out_rst;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int irq_n = 0;
  int adc_n = 0;
  int irq1_n = 0;

  always #50 clk = ~clk;

  tmx_far far (.clk_in(clk), .cmp0_rst_out(c0r), .cmp1_rst_out(c1r), .cmp2_flag_out(c2f),
    .cmp1_evt_out(c1e), .ext_irq_out(ext), .adc_en_out(aden));

  tmx_ctrl dut (.SYS_CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COMPARATOR2_LEVEL_FLAG_IN(c2f),
    .COMPARATOR1_EVENT_IN(c1e), .CMP0_RESTART_IN(c0r), .CMP1_RESTART_IN(c1r),
    .EXTERNAL_IRQ_INPUT_IN(ext), .ADC_CONVERSION_ENABLE_IN(aden), .ADC_SYNC_TRIG_OUT(adc_trig),
    .TIMER_ZERO_MATCH_IRQ_OUT(irq0), .TIMER_ONE_MATCH_IRQ_OUT(irq1), .TIMER_OUT_RESET_OUT(out_rst));

  // Pulses are counted on the falling edge, where they are settled.
  always @(negedge clk) begin
    if (irq0 === 1'b1) irq_n++;
    if (adc_trig === 1'b1) adc_n++;
    if (irq1 === 1'b1) irq1_n++;
  end

  task automatic final_report;
    $display("TB: %0d compares, %0d errors", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
  endtask : wr

  task automatic window(input int n);
    @(posedge clk);
    irq_n = 0;
    adc_n = 0;
    irq1_n = 0;
    repeat (n) @(posedge clk);
  endtask : window

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, IDX_T0_CAP_ADC, 0);
    check(rd, 32'h0);
    apb(1'b0, IDX_T0_ILOCK, 0);
    check(rd, 32'h0);
    apb(1'b0, IDX_T1_CAP_ADC, 0);
    check(rd, 32'h0);
    wr(IDX_T0_CAP_ADC, 32'hff);
    apb(1'b0, IDX_T0_CAP_ADC, 0);
    check(rd, 32'h43);
    wr(IDX_T0_ILOCK, 32'hff);
    apb(1'b0, IDX_T0_ILOCK, 0);
    check(rd, 32'h6f);
    wr(IDX_T1_CAP_ADC, 32'hff);
    apb(1'b0, IDX_T1_CAP_ADC, 0);
    check({rd[31:1], err}, 32'h2);
    wr(IDX_T0_CAP_ADC, 0);
    wr(IDX_T0_ILOCK, 0);
    wr(IDX_T1_CAP_ADC, 0);
    apb(1'b0, 16'hff90, 0);
    check(err, 1'b1);
    // Timer zero A/D trigger at channel-0 match, period 10.
    wr(IDX_T0_CR1, 9);
    wr(IDX_T0_CCR0, 3);
    wr(IDX_T0_CAP_ADC, 32'h2);
    far.set_line(5, 1'b1);
    wr(IDX_RUN_CTRL, 1);
    window(50);
    check(irq_n, 5);
    check(adc_n, 5);
    far.set_line(5, 1'b0);
    window(50);
    check(adc_n, 0);
    far.set_line(5, 1'b1);
    wr(IDX_RUN_CTRL, 0);
    wr(IDX_T0_CAP_ADC, 0);
    wr(IDX_RUN_CTRL, 1);
    window(50);
    check(adc_n, 0);
    // Bulk reload: period 10 shrinks to 5 only when the selected source restarts.
    for (int k = 0; k < 4; k++) begin
      wr(IDX_RUN_CTRL, 0);
      wr(IDX_T0_ILOCK, (k << 5) | ((k == 3) ? 2 : 0));
      wr(IDX_T0_CR1, 9);
      wr(IDX_RUN_CTRL, 1);
      wr(IDX_T0_CR1, 4);
      far.pulse((k == 0) ? 0 : k - 1);
      repeat (2) @(posedge clk);
      window(50);
      check(irq_n, (k == 0) ? 5 : 10);
    end
    // Interlocks of comparator 2 (s=0) and the external pin (s=1).
    for (int s = 0; s < 2; s++) begin
      wr(IDX_RUN_CTRL, 0);
      wr(IDX_T0_CR1, 16'h00ff);
      wr(IDX_T0_ILOCK, 1 << (2 * s));
      wr(IDX_RUN_CTRL, 1);
      far.set_line(2 + 2 * s, 1'b1);
      repeat (3) @(posedge clk);
      apb(1'b0, IDX_T0_COUNT, 0);
      check(rd, 32'h0);
      apb(1'b0, IDX_T0_COUNT, 0);
      check(rd, 32'h0);
      far.set_line(2 + 2 * s, 1'b0);
      wr(IDX_RUN_CTRL, 0);
      wr(IDX_T0_ILOCK, 2 << (2 * s));
      wr(IDX_RUN_CTRL, 1);
      repeat (20) @(posedge clk);
      far.pulse(2 + 2 * s);
      apb(1'b0, IDX_T0_COUNT, 0);
      check(rd < 8, 1'b1);
      wr(IDX_RUN_CTRL, 0);
      // output reset mode outside sync clear
      wr(IDX_T0_ILOCK, 3 << (2 * s));
      wr(IDX_RUN_CTRL, 1);
      far.pulse(2 + 2 * s);
      repeat (3) @(posedge clk);
      #1 check(out_rst, 1'b1);
      for (int i = 0; i < 600 && irq0 !== 1'b1; i++) @(negedge clk);
      check(irq0, 1'b1);
      repeat (2) @(posedge clk);
      #1 check(out_rst, 1'b0);
    end
    // Capture sources of both timers.
    wr(IDX_RUN_CTRL, 0);
    wr(IDX_T0_ILOCK, 0);
    wr(IDX_T0_CCR0, 0);
    wr(IDX_T0_CAP_ADC, 32'h41);
    wr(IDX_T1_CCR0, 0);
    wr(IDX_T1_CR1, 16'h00ff);
    wr(IDX_T1_CAP_ADC, 1);
    wr(IDX_RUN_CTRL, 3);
    repeat (10) @(posedge clk);
    far.pulse(2);
    apb(1'b0, IDX_T0_CCR0, 0);
    check(rd, 32'h0);
    far.pulse(4);
    apb(1'b0, IDX_T0_CCR0, 0);
    check(rd != 0, 1'b1);
    apb(1'b0, IDX_T1_CCR0, 0);
    check(rd, 32'h0);
    far.pulse(3);
    apb(1'b0, IDX_T1_CCR0, 0);
    check(rd != 0, 1'b1);
    // Sync start (m=1) reloads timer zero only; sync clear (m=2) reloads and restarts timer one too.
    for (int m = 1; m < 3; m++) begin
      wr(IDX_RUN_CTRL, 0);
      wr(IDX_T0_ILOCK, 32'h20);
      wr(IDX_T0_CR1, 9);
      wr(IDX_T1_CR1, 9);
      wr(IDX_T1_CCR0, 2);
      wr(IDX_T1_CAP_ADC, 32'h2);
      // no output reset in sync clear
      wr(IDX_RUN_CTRL, (m << 4) | 1);
      wr(IDX_T1_CR1, 4);
      wr(IDX_T0_CR1, 4);
      far.pulse(0);
      repeat (2) @(posedge clk);
      window(50);
      check(irq_n, 10);
      check(irq1_n, (m == 2) ? 10 : 5);
      check(adc_n, (m == 2) ? 10 : 5);
    end
    // Dual output: period follows compare three.
    wr(IDX_RUN_CTRL, 0);
    wr(IDX_T0_CR3, 16'h01ff);
    wr(IDX_RUN_CTRL, 5);
    window(1024);
    check(irq_n, 2);
    final_report();
  end
endmodule : testbench

// ### tmx_ctrl.sv
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module tmx_ctrl (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [tmx_pkg::ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Comparators and external interrupt
  input wire logic COMPARATOR2_LEVEL_FLAG_IN,
  input wire logic COMPARATOR1_EVENT_IN,
  input wire logic CMP0_RESTART_IN,
  input wire logic CMP1_RESTART_IN,
  input wire logic EXTERNAL_IRQ_INPUT_IN,
  // A/D converter
  input wire logic ADC_CONVERSION_ENABLE_IN,
  output logic ADC_SYNC_TRIG_OUT,
  // Timer events
  output logic TIMER_ZERO_MATCH_IRQ_OUT,
  output logic TIMER_ONE_MATCH_IRQ_OUT,
  output logic TIMER_OUT_RESET_OUT
);
  import tmx_pkg::*;

  logic [7:0] timer0_capture_adc_ctrl, timer0_interlock_reload_ctrl, timer1_capture_adc_ctrl, run_ctrl;
  logic [7:0] next_t0_cap, next_t0_ilock, next_t1_cap, next_run;
  logic [31:0] prdata, next_prdata, rd_word;
  logic armed, next_armed, outrst, next_outrst;
  logic cmp2_q, ext_q;
  logic [15:0] idx;
  logic aligned, hit, wr, setup;
  logic [TMX_W-1:0] count0, count1, ccr0_t0, ccr0_t1;
  logic match0, match1, adc0, adc1;
  logic comparator2_event, ext_rise, comparator1_event;
  logic capture_source_select, adc_sync_trigger_enable_t0, adc_sync_trigger_enable_t1;
  logic chan0_capture_select_t0, chan0_capture_select_t1;
  logic cap0, cap1, hold0, restart0, clear0, clear1, run0, run1, dual0;
  logic reload_src, reload0, reload1, arm_wr, outrst_set;
  logic wr_t0_ccr0, wr_t0_cr1, wr_t0_cr3, wr_t1_ccr0, wr_t1_cr1, wr_t1_cr3;
  tmx_ilock_t ext_mode, cmp2_mode;
  tmx_sync_t sync_mode;
  tmx_reload_t reload_sel;

  // Bus decode.
  assign idx = PADDR_IN[ADDR_W-1:2];
  assign aligned = PADDR_IN[1:0] == 2'b00;
  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN && hit;

  always_comb begin
    hit = 1'b0;
    if (aligned) begin
      case (idx)
        IDX_T0_CAP_ADC, IDX_T0_ILOCK, IDX_T1_CAP_ADC, IDX_RUN_CTRL: hit = 1'b1;
        IDX_T0_CCR0, IDX_T0_CR1, IDX_T0_CR3, IDX_T1_CCR0: hit = 1'b1;
        IDX_T1_CR1, IDX_T1_CR3, IDX_T0_COUNT, IDX_T1_COUNT: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
  end

  // Zero wait states; an unmapped word answers with an error.
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !hit;

  // Field views.
  assign capture_source_select = timer0_capture_adc_ctrl[CAPSRC_BIT];
  assign adc_sync_trigger_enable_t0 = timer0_capture_adc_ctrl[ADEN_BIT];
  assign chan0_capture_select_t0 = timer0_capture_adc_ctrl[CCS_BIT];
  assign adc_sync_trigger_enable_t1 = timer1_capture_adc_ctrl[ADEN_BIT];
  assign chan0_capture_select_t1 = timer1_capture_adc_ctrl[CCS_BIT];
  assign reload_sel = tmx_reload_t'(timer0_interlock_reload_ctrl[RELOAD_HI:RELOAD_LO]);
  assign ext_mode = tmx_ilock_t'(timer0_interlock_reload_ctrl[EXT_HI:EXT_LO]);
  assign cmp2_mode = tmx_ilock_t'(timer0_interlock_reload_ctrl[CMP2_HI:CMP2_LO]);
  assign sync_mode = tmx_sync_t'(run_ctrl[SYNC_HI:SYNC_LO]);
  assign dual0 = run_ctrl[DUAL0_BIT];

  // Inputs are synchronous, so one flop per line is enough for edge detection.
  assign comparator2_event = COMPARATOR2_LEVEL_FLAG_IN && !cmp2_q;
  assign ext_rise = EXTERNAL_IRQ_INPUT_IN && !ext_q;
  assign comparator1_event = COMPARATOR1_EVENT_IN;

  assign cap0 = capture_source_select ? ext_rise : comparator2_event;
  assign cap1 = comparator1_event;

  // Interlock decode for timer zero.
  always_comb begin
    hold0 = 1'b0;
    restart0 = CMP0_RESTART_IN || CMP1_RESTART_IN;
    outrst_set = 1'b0;
    case (ext_mode)
      IL_OFF: ;
      IL_HOLD: hold0 = hold0 || EXTERNAL_IRQ_INPUT_IN;
      IL_RESTART: restart0 = restart0 || ext_rise;
      IL_OUTRST: outrst_set = outrst_set || ext_rise;
      default: ;
    endcase
    case (cmp2_mode)
      IL_OFF: ;
      IL_HOLD: hold0 = hold0 || COMPARATOR2_LEVEL_FLAG_IN;
      IL_RESTART: restart0 = restart0 || comparator2_event;
      IL_OUTRST: outrst_set = outrst_set || comparator2_event;
      default: ;
    endcase
  end

  always_comb begin
    case (reload_sel)
      RL_NONE: reload_src = 1'b0;
      RL_CMP0: reload_src = CMP0_RESTART_IN;
      RL_CMP1: reload_src = CMP1_RESTART_IN;
      RL_CMP2: reload_src = cmp2_mode == IL_RESTART && comparator2_event;
      default: reload_src = 1'b0;
    endcase
  end
  assign reload0 = armed && reload_src;
  // timer one joins in sync clear.
  assign reload1 = reload0 && sync_mode == SYNC_CLEAR;

  // arming write depends on output mode.
  assign arm_wr = dual0 ? wr_t0_cr3 : wr_t0_cr1;

  // Sync modes start timer one with timer zero; prohibited code behaves as alone.
  assign run0 = run_ctrl[RUN0_BIT];
  assign run1 = (sync_mode == SYNC_START || sync_mode == SYNC_CLEAR) ? run0 : run_ctrl[RUN1_BIT];
  assign clear0 = hold0 || restart0;
  assign clear1 = sync_mode == SYNC_CLEAR && clear0;

  assign wr_t0_ccr0 = wr && idx == IDX_T0_CCR0;
  assign wr_t0_cr1 = wr && idx == IDX_T0_CR1;
  assign wr_t0_cr3 = wr && idx == IDX_T0_CR3;
  assign wr_t1_ccr0 = wr && idx == IDX_T1_CCR0;
  assign wr_t1_cr1 = wr && idx == IDX_T1_CR1;
  assign wr_t1_cr3 = wr && idx == IDX_T1_CR3;

  // Read mux.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (idx)
      IDX_T0_CAP_ADC: rd_word[7:0] = timer0_capture_adc_ctrl;
      IDX_T0_ILOCK: rd_word[7:0] = timer0_interlock_reload_ctrl;
      IDX_T1_CAP_ADC: rd_word[7:0] = timer1_capture_adc_ctrl;
      IDX_RUN_CTRL: rd_word[7:0] = run_ctrl;
      IDX_T0_CCR0: rd_word[TMX_W-1:0] = ccr0_t0;
      IDX_T1_CCR0: rd_word[TMX_W-1:0] = ccr0_t1;
      IDX_T0_COUNT: rd_word[TMX_W-1:0] = count0;
      IDX_T1_COUNT: rd_word[TMX_W-1:0] = count1;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Register group next values.
  always_comb begin
    next_t0_cap = timer0_capture_adc_ctrl;
    next_t0_ilock = timer0_interlock_reload_ctrl;
    next_t1_cap = timer1_capture_adc_ctrl;
    next_run = run_ctrl;
    next_prdata = prdata;
    // Read data is taken in the setup phase so it leaves a flop.
    if (setup && !PWRITE_IN && hit) begin
      next_prdata = rd_word;
    end
    if (wr && idx == IDX_T0_CAP_ADC) begin
      next_t0_cap = PWDATA_IN[7:0] & MASK_T0_CAP_ADC;
    end
    if (wr && idx == IDX_T0_ILOCK) begin
      next_t0_ilock = PWDATA_IN[7:0] & MASK_T0_ILOCK;
    end
    if (wr && idx == IDX_T1_CAP_ADC) begin
      next_t1_cap = PWDATA_IN[7:0] & MASK_T1_CAP_ADC;
    end
    if (wr && idx == IDX_RUN_CTRL) begin
      next_run = PWDATA_IN[7:0] & MASK_RUN_CTRL;
    end
    // A new arming write beats the reload that consumes the old one.
    next_armed = armed;
    if (reload0) begin
      next_armed = 1'b0;
    end
    if (arm_wr) begin
      next_armed = 1'b1;
    end
    // Output reset holds until the next timer zero interrupt; a new edge wins.
    next_outrst = outrst;
    if (match0) begin
      next_outrst = 1'b0;
    end
    if (outrst_set) begin
      next_outrst = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      timer0_capture_adc_ctrl <= CTL_RESET;
      timer0_interlock_reload_ctrl <= CTL_RESET;
      timer1_capture_adc_ctrl <= CTL_RESET;
      run_ctrl <= CTL_RESET;
      prdata <= 32'h0000_0000;
      armed <= 1'b0;
      outrst <= 1'b0;
      cmp2_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      timer0_capture_adc_ctrl <= next_t0_cap;
      timer0_interlock_reload_ctrl <= next_t0_ilock;
      timer1_capture_adc_ctrl <= next_t1_cap;
      run_ctrl <= next_run;
      prdata <= next_prdata;
      armed <= next_armed;
      outrst <= next_outrst;
      cmp2_q <= COMPARATOR2_LEVEL_FLAG_IN;
      ext_q <= EXTERNAL_IRQ_INPUT_IN;
    end
  end

  tmx_unit #(.W(TMX_W)) u_timer_x_zero (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .run_in(run0),
    .clear_in(clear0),
    .dual_in(dual0),
    .ccs_in(chan0_capture_select_t0),
    .aden_in(adc_sync_trigger_enable_t0),
    .cap_in(cap0),
    .load_in(reload0),
    .wr_ccr0_in(wr_t0_ccr0),
    .wr_cr1_in(wr_t0_cr1),
    .wr_cr3_in(wr_t0_cr3),
    .wdata_in(PWDATA_IN[TMX_W-1:0]),
    .count_out(count0),
    .ccr0_out(ccr0_t0),
    .match_out(match0),
    .adc_out(adc0)
  );

  // Timer one has no dual-output setting here and always ends on compare one.
  tmx_unit #(.W(TMX_W)) u_timer_x_one (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .run_in(run1),
    .clear_in(clear1),
    .dual_in(1'b0),
    .ccs_in(chan0_capture_select_t1),
    .aden_in(adc_sync_trigger_enable_t1),
    .cap_in(cap1),
    .load_in(reload1),
    .wr_ccr0_in(wr_t1_ccr0),
    .wr_cr1_in(wr_t1_cr1),
    .wr_cr3_in(wr_t1_cr3),
    .wdata_in(PWDATA_IN[TMX_W-1:0]),
    .count_out(count1),
    .ccr0_out(ccr0_t1),
    .match_out(match1),
    .adc_out(adc1)
  );

  assign ADC_SYNC_TRIG_OUT = (adc0 || adc1) && ADC_CONVERSION_ENABLE_IN;
  assign PRDATA_OUT = prdata;
  assign TIMER_ZERO_MATCH_IRQ_OUT = match0;
  assign TIMER_ONE_MATCH_IRQ_OUT = match1;
  assign TIMER_OUT_RESET_OUT = outrst;

  adc_gate_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    ADC_SYNC_TRIG_OUT |-> ADC_CONVERSION_ENABLE_IN) else $error("A/D trigger while conversion off");
  adc_disable_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (!adc_sync_trigger_enable_t0 && !adc_sync_trigger_enable_t1)[*2] |-> !ADC_SYNC_TRIG_OUT)
    else $error("A/D trigger with both enables clear");
  ctl_reset_a: assert property (@(posedge SYS_CLK_IN)
    $fell(RST_IN) |-> timer0_capture_adc_ctrl == 8'h00 && timer0_interlock_reload_ctrl == 8'h00
      && timer1_capture_adc_ctrl == 8'h00) else $error("Control register not clear after reset");
  t1_bits_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    timer1_capture_adc_ctrl[7:2] == 6'h00 && timer0_capture_adc_ctrl[5:2] == 4'h0
      && !timer0_interlock_reload_ctrl[7] && !timer0_interlock_reload_ctrl[4])
    else $error("Reserved control bit set");
  t1_reload_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    reload1 |-> sync_mode == SYNC_CLEAR && reload0) else $error("Timer one reload outside sync clear");
  reload_cause_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    reload0 |-> armed && reload_sel != RL_NONE) else $error("Reload without arming or source");
  arm_write_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (wr_t0_cr1 && !dual0) |=> armed) else $error("Compare one write did not arm reload");
  ext_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ext_mode == IL_HOLD && EXTERNAL_IRQ_INPUT_IN)[*2] |=> count0 == 16'h0000)
    else $error("Timer zero counted during external hold");
  cmp2_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (cmp2_mode == IL_HOLD && COMPARATOR2_LEVEL_FLAG_IN) |=> count0 == 16'h0000 && !match0)
    else $error("Timer zero counted during comparator hold");
  out_reset_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    (ext_mode == IL_OUTRST && ext_rise) |=> TIMER_OUT_RESET_OUT) else $error("Output reset not set");

  // These tie each trigger to what the timers, arming and outputs do one cycle later; the comparator 0 and 2 reload checks look at the same cycle.
  cmp2_capture_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    run0 && chan0_capture_select_t0 && !capture_source_select && comparator2_event |=> ccr0_t0 == $past(count0))
    else $error("Comparator 2 event did not capture");
  ext_capture_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    run0 && chan0_capture_select_t0 && capture_source_select && ext_rise |=> ccr0_t0 == $past(count0))
    else $error("External pin edge did not capture");
  t1_capture_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    run1 && chan0_capture_select_t1 && COMPARATOR1_EVENT_IN |=> ccr0_t1 == $past(count1))
    else $error("Comparator 1 event did not capture");
  compare_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    run0 && !chan0_capture_select_t0 && !reload0 |=> $stable(ccr0_t0)) else $error("Compare register changed");
  adc_match_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    run0 && adc_sync_trigger_enable_t0 && !chan0_capture_select_t0 && count0 == ccr0_t0
      |=> ADC_SYNC_TRIG_OUT || !ADC_CONVERSION_ENABLE_IN) else $error("Timer zero match gave no A/D trigger");
  t1_adc_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    run1 && adc_sync_trigger_enable_t1 && !chan0_capture_select_t1 && count1 == ccr0_t1
      |=> ADC_SYNC_TRIG_OUT || !ADC_CONVERSION_ENABLE_IN) else $error("Timer one match gave no A/D trigger");
  reload_cmp0_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    armed && reload_sel == RL_CMP0 && CMP0_RESTART_IN |-> reload0)
    else $error("Comparator 0 restart did not reload");
  cmp2_reload_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    reload0 && reload_sel == RL_CMP2 |-> cmp2_mode == IL_RESTART)
    else $error("Comparator 2 reload outside restart mode");
  t1_noload_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    reload0 && sync_mode != SYNC_CLEAR && run1 && !chan0_capture_select_t1 |=> $stable(ccr0_t1))
    else $error("Timer one reloaded outside sync clear");
  arm_dual_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    wr_t0_cr3 && dual0 |=> armed) else $error("Compare three write did not arm reload");
  ext_restart_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    ext_mode == IL_RESTART && ext_rise |=> count0 == 16'h0000) else $error("External edge did not restart");
  out_release_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    match0 && !outrst_set |=> !TIMER_OUT_RESET_OUT) else $error("Output reset outlived the interrupt");
  cmp2_restart_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    cmp2_mode == IL_RESTART && comparator2_event |=> count0 == 16'h0000)
    else $error("Comparator 2 did not restart");
  cmp2_outrst_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    cmp2_mode == IL_OUTRST && comparator2_event |=> TIMER_OUT_RESET_OUT)
    else $error("Comparator 2 output reset not set");
  sync_clear_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
    sync_mode == SYNC_CLEAR && clear0 |=> count1 == 16'h0000)
    else $error("Timer one not cleared with timer zero");
endmodule : tmx_ctrl

// ### tmx_far.sv
`timescale 1ns/1ps
module tmx_far (
  // Clock
  input wire logic clk_in,
  // Comparator and pin events
  output logic cmp0_rst_out,
  output logic cmp1_rst_out,
  output logic cmp2_flag_out,
  output logic cmp1_evt_out,
  output logic ext_irq_out,
  // A/D converter
  output logic adc_en_out
);
  initial begin
    {cmp0_rst_out, cmp1_rst_out, cmp2_flag_out, cmp1_evt_out, ext_irq_out, adc_en_out} = 6'h00;
  end

  // Lines move just after a rising edge, so the block sees every level for whole cycles.
  task automatic set_line(input int sel, input logic val);
    @(posedge clk_in);
    case (sel)
      0: cmp0_rst_out <= val;
      1: cmp1_rst_out <= val;
      2: cmp2_flag_out <= val;
      3: cmp1_evt_out <= val;
      4: ext_irq_out <= val;
      default: adc_en_out <= val;
    endcase
  endtask : set_line

  // conversion enable level
  // A pulse is one cycle high, which is also a rising edge on the level lines.
  task automatic pulse(input int sel);
    set_line(sel, 1'b1);
    set_line(sel, 1'b0);
  endtask : pulse
endmodule : tmx_far

// ### tmx_pkg.sv
// How it works
// - Timer zero captures on comparator 2 or external irq.
// - Timer one captures on comparator 1 only.
// - Enabled timer fires A/D trigger on channel-0 match.
// - Channel-0 register compares at 0, captures at 1.
// - A/D trigger passes only while conversion enabled.
// - Reset clears all four control registers.
// - A/D registers stay writable while timers run.
// - Timer one register holds only bits 1 and 0.
// - Reload select picks comparator 0, 1 or 2.
// - Bulk reload only on restart-mode interlock.
// - Timer one reloads only in sync clear.
// - Reload armed by compare one or three write.
// - External irq interlock: off, hold, restart, output reset.
// - Comparator 2 interlock: off, hold, restart, output reset.
// - Timer one mode: alone, sync start, sync clear.
// - Timer zero irq on compare one or three.
package tmx_pkg;
  localparam int TMX_W = 16;
  localparam int ADDR_W = 18;
  // Word indices; the byte address is four times the index.
  localparam logic [15:0] IDX_T0_CAP_ADC = 16'hff80;
  localparam logic [15:0] IDX_T0_ILOCK = 16'hff81;
  localparam logic [15:0] IDX_T1_CAP_ADC = 16'hff96;
  localparam logic [15:0] IDX_RUN_CTRL = 16'hffa0;
  localparam logic [15:0] IDX_T0_CCR0 = 16'hffa2;
  localparam logic [15:0] IDX_T0_CR1 = 16'hffa3;
  localparam logic [15:0] IDX_T0_CR3 = 16'hffa4;
  localparam logic [15:0] IDX_T1_CCR0 = 16'hffa5;
  localparam logic [15:0] IDX_T1_CR1 = 16'hffa6;
  localparam logic [15:0] IDX_T1_CR3 = 16'hffa7;
  localparam logic [15:0] IDX_T0_COUNT = 16'hffa8;
  localparam logic [15:0] IDX_T1_COUNT = 16'hffa9;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] MASK_T0_CAP_ADC = 8'h43;
  localparam logic [7:0] MASK_T0_ILOCK = 8'h6f;
  localparam logic [7:0] MASK_T1_CAP_ADC = 8'h03;
  localparam logic [7:0] MASK_RUN_CTRL = 8'h37;
  localparam int CAPSRC_BIT = 6;
  localparam int ADEN_BIT = 1;
  localparam int CCS_BIT = 0;
  localparam int RELOAD_HI = 6;
  localparam int RELOAD_LO = 5;
  localparam int EXT_HI = 3;
  localparam int EXT_LO = 2;
  localparam int CMP2_HI = 1;
  localparam int CMP2_LO = 0;
  localparam int RUN0_BIT = 0;
  localparam int RUN1_BIT = 1;
  localparam int DUAL0_BIT = 2;
  localparam int SYNC_HI = 5;
  localparam int SYNC_LO = 4;
  typedef enum logic [1:0] {IL_OFF, IL_HOLD, IL_RESTART, IL_OUTRST} tmx_ilock_t;
  typedef enum logic [1:0] {SYNC_NONE, SYNC_START, SYNC_CLEAR, SYNC_BAD} tmx_sync_t;
  typedef enum logic [1:0] {RL_NONE, RL_CMP0, RL_CMP1, RL_CMP2} tmx_reload_t;
endpackage : tmx_pkg

// ### tmx_unit.sv
`timescale 1ns/1ps
module tmx_unit #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control
  input wire logic run_in,
  input wire logic clear_in,
  input wire logic dual_in,
  input wire logic ccs_in,
  input wire logic aden_in,
  input wire logic cap_in,
  input wire logic load_in,
  // Buffer writes
  input wire logic wr_ccr0_in,
  input wire logic wr_cr1_in,
  input wire logic wr_cr3_in,
  input wire logic [W-1:0] wdata_in,
  // Status
  output logic [W-1:0] count_out,
  output logic [W-1:0] ccr0_out,
  output logic match_out,
  output logic adc_out
);
  import tmx_pkg::*;
  logic [W-1:0] count, ccr0_buf, cr1_buf, cr3_buf, ccr0_act, cr1_act, cr3_act;
  logic [W-1:0] next_count, next_ccr0_buf, next_cr1_buf, next_cr3_buf;
  logic [W-1:0] next_ccr0_act, next_cr1_act, next_cr3_act, period;
  logic match, adc, next_match, next_adc;

  always_comb begin
    next_ccr0_buf = wr_ccr0_in ? wdata_in : ccr0_buf;
    next_cr1_buf = wr_cr1_in ? wdata_in : cr1_buf;
    next_cr3_buf = wr_cr3_in ? wdata_in : cr3_buf;
    next_ccr0_act = ccr0_act;
    next_cr1_act = cr1_act;
    next_cr3_act = cr3_act;
    // A stopped timer follows its buffers, a running one only on a bulk load.
    if (!run_in || load_in) begin
      next_ccr0_act = next_ccr0_buf;
      next_cr1_act = next_cr1_buf;
      next_cr3_act = next_cr3_buf;
    end
    if (ccs_in && cap_in && run_in) begin
      next_ccr0_act = count;
    end
    period = dual_in ? cr3_act : cr1_act;
    if (!run_in || clear_in || count == period) begin
      next_count = '0;
    end else begin
      next_count = count + 1'b1;
    end
    next_match = run_in && !clear_in && count == period;
    next_adc = aden_in && !ccs_in && run_in && count == ccr0_act;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
      ccr0_buf <= '0;
      cr1_buf <= '0;
      cr3_buf <= '0;
      ccr0_act <= '0;
      cr1_act <= '0;
      cr3_act <= '0;
      match <= 1'b0;
      adc <= 1'b0;
    end else begin
      count <= next_count;
      ccr0_buf <= next_ccr0_buf;
      cr1_buf <= next_cr1_buf;
      cr3_buf <= next_cr3_buf;
      ccr0_act <= next_ccr0_act;
      cr1_act <= next_cr1_act;
      cr3_act <= next_cr3_act;
      match <= next_match;
      adc <= next_adc;
    end
  end

  assign count_out = count;
  assign ccr0_out = ccr0_act;
  assign match_out = match;
  assign adc_out = adc;
endmodule : tmx_unit
